// [sensor_regs_pkg.sv]
package sensor_regs_pkg;

  // ==========================================================================
  // Register pointer decode
  localparam logic [3:0] PTR_TEMP      = 4'h0;
  localparam logic [3:0] PTR_CFG       = 4'h1;
  localparam logic [3:0] PTR_NVM_FIRST = 4'h1;
  localparam logic [3:0] PTR_NVM_LAST  = 4'hD;
  localparam logic [3:0] PTR_DIE       = 4'hF;
  localparam int         NVM_WORDS     = 13;

  // ==========================================================================
  // Shadow word indices (pointer minus one)
  localparam int IDX_CFG = 0;
  localparam int IDX_HIGH [2] = '{1, 3};
  localparam int IDX_LOW  [2] = '{2, 4};

  // ==========================================================================
  // Field positions
  localparam int TEMP_NUS_BIT  = 0;
  localparam int TEMP_BUSY_BIT = 1;
  localparam int TEMP_LSB      = 2;
  localparam int TEMP_W        = 14;
  localparam int CFG_RATE_LSB  = 13;
  localparam int CFG_OS_BIT    = 12;
  localparam int CFG_SD_BIT    = 11;
  localparam int CFG_RST_BIT   = 1;
  localparam int FH_BIT   [2] = '{10, 6};
  localparam int FL_BIT   [2] = '{9, 5};
  localparam int MODE_BIT [2] = '{8, 4};
  localparam int POL_BIT  [2] = '{7, 3};
  localparam int LIMIT_LSB     = 2;

  // ==========================================================================
  // Write masks and factory contents
  localparam logic [15:0] CFG_RW_MASK = 16'hE998;
  localparam logic [15:0] LIMIT_MASK  = 16'hFFFC;
  localparam logic [15:0] CFG_RESET   = 16'hA000;
  localparam logic [15:0] HIGH_RESET  = 16'h7FFC;
  localparam logic [15:0] LOW_RESET   = 16'h8000;
  localparam logic [15:0] GP_RESET    = 16'h0000;
  localparam logic [15:0] NVM_FACTORY [NVM_WORDS] = '{CFG_RESET, HIGH_RESET, LOW_RESET,
    HIGH_RESET, LOW_RESET, GP_RESET, GP_RESET, GP_RESET, GP_RESET, GP_RESET, GP_RESET,
    GP_RESET, GP_RESET};

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ             = 125;
  localparam int unsigned CYCLES_PER_MS       = CLK_MHZ * 1000;
  localparam int unsigned PROG_TIME_MS        = 16;
  localparam int unsigned PROG_CYCLES         = PROG_TIME_MS * CYCLES_PER_MS;
  localparam int unsigned READ_STRETCH_US     = 100;
  localparam int unsigned READ_STRETCH_CYCLES = READ_STRETCH_US * CLK_MHZ;
  localparam int unsigned RATE_MS [8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};

  typedef enum logic [1:0] {CV_IDLE, CV_CONV, CV_WAIT} conv_state_t;

endpackage

// [sensor_regs_nvm_shadow.sv]
`timescale 1ns/1ps
`default_nettype none

module sensor_regs_nvm_shadow #(
  parameter int unsigned PROG_CYCLES   = sensor_regs_pkg::PROG_CYCLES,
  parameter int unsigned STRETCH_CYCLES = sensor_regs_pkg::READ_STRETCH_CYCLES,
  parameter int unsigned MS_CYCLES     = sensor_regs_pkg::CYCLES_PER_MS,
  // Arbitrary value, not tied to any real part
  parameter logic [15:0] DIE_ID        = 16'h5A3C
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register access
  input  wire logic [3:0]  register_pointer_bits,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  // Converter
  output logic             conv_start,
  input  wire logic        adc_done,
  input  wire logic [13:0] adc_result,
  // Open-drain alert pins
  output logic             alert_output_one_o,
  output logic             alert_output_one_oe_n,
  output logic             alert_output_two_o,
  output logic             alert_output_two_oe_n
);

  // ==========================================================================
  // Storage
  logic [15:0] nvm_ff [sensor_regs_pkg::NVM_WORDS] = sensor_regs_pkg::NVM_FACTORY;
  logic [15:0] shadow_ff [sensor_regs_pkg::NVM_WORDS];
  logic        nvm_unlock_bit_ff;
  logic        soft_rst_ff;
  logic        busy_ff;
  logic [31:0] prog_cnt_ff;
  logic [3:0]  prog_idx_ff;
  logic [15:0] prog_data_ff;
  logic [13:0] temp_ff;
  logic [1:0]  high_flag_ff;
  logic [1:0]  low_flag_ff;
  logic        reload;
  logic        wr_ok;
  logic        ptr_backed;
  logic [3:0]  ptr_idx;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [15:0] cfg_word;
  logic [15:0] rd_value;
  logic        rd_wait_ff;
  logic [31:0] rd_cnt_ff;
  logic [15:0] rd_hold_ff;

  assign reload     = rst | soft_rst_ff;
  assign wr_ok      = wr_en & ~busy_ff;
  assign ptr_backed = (register_pointer_bits >= sensor_regs_pkg::PTR_NVM_FIRST) &&
                      (register_pointer_bits <= sensor_regs_pkg::PTR_NVM_LAST);
  assign ptr_idx    = register_pointer_bits - 4'h1;
  assign cfg_wr     = wr_ok && (register_pointer_bits == sensor_regs_pkg::PTR_CFG);
  assign cfg_rd     = rd_en && ~rd_wait_ff &&
                      (register_pointer_bits == sensor_regs_pkg::PTR_CFG);

  function automatic logic [15:0] wmask(input logic [3:0] idx);
    if (idx == 4'(sensor_regs_pkg::IDX_CFG))
      wmask = sensor_regs_pkg::CFG_RW_MASK;
    else if (idx <= 4'(sensor_regs_pkg::IDX_LOW[1]))
      wmask = sensor_regs_pkg::LIMIT_MASK;
    else
      wmask = 16'hFFFF;
  endfunction

  // ==========================================================================
  // Lock, software reset, shadow registers
  always_ff @(posedge clk)
  begin
    if (reload)
      nvm_unlock_bit_ff <= 1'b0;
    else if (wr_ok && register_pointer_bits == sensor_regs_pkg::PTR_TEMP)
      nvm_unlock_bit_ff <= wr_data[sensor_regs_pkg::TEMP_NUS_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (reload)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= cfg_wr && wr_data[sensor_regs_pkg::CFG_RST_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (reload)
    begin
      for (int i = 0; i < sensor_regs_pkg::NVM_WORDS; i++)
        shadow_ff[i] <= nvm_ff[i];
    end
    else if (wr_ok && ptr_backed)
    begin
      // General words ignore locked writes; config and limits keep logic copy
      if (nvm_unlock_bit_ff || ptr_idx <= 4'(sensor_regs_pkg::IDX_LOW[1]))
        shadow_ff[ptr_idx] <= wr_data & wmask(ptr_idx);
    end
  end

  // ==========================================================================
  // Programming engine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_ff      <= 1'b0;
      prog_cnt_ff  <= 32'h0000_0000;
      prog_idx_ff  <= 4'h0;
      prog_data_ff <= 16'h0000;
    end
    else if (!busy_ff && wr_ok && ptr_backed && nvm_unlock_bit_ff)
    begin
      // Fixed one-edge start so every chained device begins together
      busy_ff      <= 1'b1;
      prog_cnt_ff  <= PROG_CYCLES - 1;
      prog_idx_ff  <= ptr_idx;
      prog_data_ff <= wr_data & wmask(ptr_idx);
    end
    else if (busy_ff)
    begin
      if (prog_cnt_ff == 32'h0000_0000)
        busy_ff <= 1'b0;
      else
        prog_cnt_ff <= prog_cnt_ff - 32'h0000_0001;
    end
  end

  // No reset: contents must survive every reset
  always_ff @(posedge clk)
  begin
    if (!rst && busy_ff && prog_cnt_ff == 32'h0000_0000)
      nvm_ff[prog_idx_ff] <= prog_data_ff;
  end

  // ==========================================================================
  // Conversion control
  sensor_regs_pkg::conv_state_t cv_state_ff;
  logic        restart_ff;
  logic        oneshot_ff;
  logic [31:0] per_cnt_ff;
  logic [31:0] period;
  logic        sd_bit;
  logic        conv_take;

  assign sd_bit = shadow_ff[sensor_regs_pkg::IDX_CFG][sensor_regs_pkg::CFG_SD_BIT];
  assign period = sensor_regs_pkg::RATE_MS[shadow_ff[sensor_regs_pkg::IDX_CFG][15:13]]
                  * MS_CYCLES;
  assign conv_take = (cv_state_ff == sensor_regs_pkg::CV_CONV) && adc_done &&
                     !cfg_wr && !restart_ff;

  always_ff @(posedge clk)
  begin
    if (reload)
    begin
      cv_state_ff <= sensor_regs_pkg::CV_IDLE;
      restart_ff  <= 1'b1;
      oneshot_ff  <= 1'b0;
      per_cnt_ff  <= 32'h0000_0000;
      conv_start  <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (cfg_wr)
      begin
        // Abort now; next edge acts on the freshly written bits
        cv_state_ff <= sensor_regs_pkg::CV_IDLE;
        restart_ff  <= 1'b1;
        oneshot_ff  <= wr_data[sensor_regs_pkg::CFG_OS_BIT] &&
                       wr_data[sensor_regs_pkg::CFG_SD_BIT];
      end
      else if (restart_ff)
      begin
        restart_ff <= 1'b0;
        if (!sd_bit || oneshot_ff)
        begin
          conv_start  <= 1'b1;
          cv_state_ff <= sensor_regs_pkg::CV_CONV;
          per_cnt_ff  <= 32'h0000_0000;
        end
      end
      else
      begin
        case (cv_state_ff)
          sensor_regs_pkg::CV_CONV:
          begin
            per_cnt_ff <= per_cnt_ff + 32'h0000_0001;
            if (adc_done)
            begin
              oneshot_ff  <= 1'b0;
              cv_state_ff <= sd_bit ? sensor_regs_pkg::CV_IDLE
                                    : sensor_regs_pkg::CV_WAIT;
            end
          end
          sensor_regs_pkg::CV_WAIT:
          begin
            if (per_cnt_ff >= period - 32'h0000_0001)
            begin
              conv_start  <= 1'b1;
              cv_state_ff <= sensor_regs_pkg::CV_CONV;
              per_cnt_ff  <= 32'h0000_0000;
            end
            else
              per_cnt_ff <= per_cnt_ff + 32'h0000_0001;
          end
          sensor_regs_pkg::CV_IDLE:
            per_cnt_ff <= 32'h0000_0000;
          default:
            cv_state_ff <= sensor_regs_pkg::CV_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Result and comparators
  logic signed [13:0] hi_lim [2];
  logic signed [13:0] lo_lim [2];
  logic        [1:0]  above;
  logic        [1:0]  below;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      hi_lim[c] = $signed(shadow_ff[sensor_regs_pkg::IDX_HIGH[c]][15:2]);
      lo_lim[c] = $signed(shadow_ff[sensor_regs_pkg::IDX_LOW[c]][15:2]);
      above[c]  = conv_take && ($signed(adc_result) > hi_lim[c]);
      below[c]  = conv_take && ($signed(adc_result) < lo_lim[c]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reload)
      temp_ff <= 14'h0000;
    else if (conv_take)
      temp_ff <= adc_result;
  end

  always_ff @(posedge clk)
  begin
    if (reload)
    begin
      high_flag_ff <= 2'b00;
      low_flag_ff  <= 2'b00;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (shadow_ff[sensor_regs_pkg::IDX_CFG][sensor_regs_pkg::MODE_BIT[c]])
        begin
          low_flag_ff[c] <= 1'b0;
          if (above[c])
            high_flag_ff[c] <= 1'b1;
          else if (below[c])
            high_flag_ff[c] <= 1'b0;
        end
        else
        begin
          // Set beats the read clear in the same cycle
          high_flag_ff[c] <= above[c] | (high_flag_ff[c] & ~cfg_rd);
          low_flag_ff[c]  <= below[c] | (low_flag_ff[c] & ~cfg_rd);
        end
      end
    end
  end

  // ==========================================================================
  // Alert pins
  logic [1:0] drive_low;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
      drive_low[c] = (high_flag_ff[c] | low_flag_ff[c]) ^
                     shadow_ff[sensor_regs_pkg::IDX_CFG][sensor_regs_pkg::POL_BIT[c]];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alert_output_one_o    <= 1'b0;
      alert_output_two_o    <= 1'b0;
      alert_output_one_oe_n <= 1'b1;
      alert_output_two_oe_n <= 1'b1;
    end
    else
    begin
      alert_output_one_o    <= 1'b0;
      alert_output_two_o    <= 1'b0;
      alert_output_one_oe_n <= ~drive_low[0];
      alert_output_two_oe_n <= ~drive_low[1];
    end
  end

  // ==========================================================================
  // Read path
  always_comb
  begin
    cfg_word = shadow_ff[sensor_regs_pkg::IDX_CFG];
    for (int c = 0; c < 2; c++)
    begin
      cfg_word[sensor_regs_pkg::FH_BIT[c]] = high_flag_ff[c];
      cfg_word[sensor_regs_pkg::FL_BIT[c]] = low_flag_ff[c];
    end
    if (register_pointer_bits == sensor_regs_pkg::PTR_TEMP)
      rd_value = {temp_ff, busy_ff, nvm_unlock_bit_ff};
    else if (register_pointer_bits == sensor_regs_pkg::PTR_CFG)
      rd_value = cfg_word;
    else if (ptr_backed)
      rd_value = shadow_ff[ptr_idx];
    else if (register_pointer_bits == sensor_regs_pkg::PTR_DIE)
      rd_value = DIE_ID;
    else
      rd_value = 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_wait_ff <= 1'b0;
      rd_cnt_ff  <= 32'h0000_0000;
      rd_hold_ff <= 16'h0000;
      rd_data    <= 16'h0000;
      rd_valid   <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (rd_wait_ff)
      begin
        if (rd_cnt_ff == 32'h0000_0000)
        begin
          rd_wait_ff <= 1'b0;
          rd_data    <= rd_hold_ff;
          rd_valid   <= 1'b1;
        end
        else
          rd_cnt_ff <= rd_cnt_ff - 32'h0000_0001;
      end
      else if (rd_en && ptr_backed)
      begin
        rd_wait_ff <= 1'b1;
        rd_cnt_ff  <= STRETCH_CYCLES - 1;
        rd_hold_ff <= rd_value;
      end
      else if (rd_en)
      begin
        rd_data  <= rd_value;
        rd_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence s_prog_start;
    !busy_ff && wr_en && ptr_backed && nvm_unlock_bit_ff;
  endsequence

  sequence s_locked_wr;
    !nvm_unlock_bit_ff && !busy_ff && wr_en && ptr_backed;
  endsequence

  chk_prog_busy_hold: assert property (@(posedge clk) disable iff (reload)
    s_prog_start |=> busy_ff [*8])
    else $error("programming cycle ended too early");

  chk_locked_no_prog: assert property (@(posedge clk) disable iff (reload)
    s_locked_wr |=> !busy_ff)
    else $error("locked write started programming");

  chk_busy_blocks_nus: assert property (@(posedge clk) disable iff (reload)
    busy_ff && wr_en && register_pointer_bits == sensor_regs_pkg::PTR_TEMP
    |=> $stable(nvm_unlock_bit_ff))
    else $error("write accepted while programming");

  chk_read_stretch: assert property (@(posedge clk) disable iff (rst)
    !rd_wait_ff && rd_en && ptr_backed |=> !rd_valid [*8])
    else $error("stored location read answered without delay");

  chk_fast_read: assert property (@(posedge clk) disable iff (rst)
    !rd_wait_ff && rd_en && register_pointer_bits == sensor_regs_pkg::PTR_DIE
    |=> rd_valid && rd_data == DIE_ID)
    else $error("die id read wrong");

  chk_temp_after_reset: assert property (@(posedge clk)
    reload |=> temp_ff == 14'h0000)
    else $error("temperature not cleared by reset");

  chk_os_reads_zero: assert property (@(posedge clk) disable iff (rst)
    !rd_wait_ff && rd_en && register_pointer_bits == sensor_regs_pkg::PTR_CFG
    |=> !rd_hold_ff[sensor_regs_pkg::CFG_OS_BIT])
    else $error("single conversion bit read as one");

  chk_shutdown_idle: assert property (@(posedge clk) disable iff (reload)
    cv_state_ff == sensor_regs_pkg::CV_IDLE && sd_bit && !oneshot_ff && !restart_ff && !cfg_wr
    |=> !conv_start)
    else $error("conversion started in shutdown");

  chk_thresh_low_zero: assert property (@(posedge clk) disable iff (reload)
    shadow_ff[sensor_regs_pkg::IDX_CFG][sensor_regs_pkg::MODE_BIT[0]] |=> !low_flag_ff[0])
    else $error("threshold mode low flag set");

  chk_alert_polarity: assert property (@(posedge clk) disable iff (rst)
    ##1 alert_output_one_oe_n == ~($past(high_flag_ff[0] | low_flag_ff[0]) ^
    $past(shadow_ff[sensor_regs_pkg::IDX_CFG][sensor_regs_pkg::POL_BIT[0]])))
    else $error("alert pin polarity wrong");

endmodule

`default_nettype wire

// [sensor_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Converter on the far side: answers a start after a fixed delay; a new start restarts the count
module sensor_adc_model #(
  parameter int DELAY = 5
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter handshake
  input  wire logic        conv_start,
  input  wire logic [13:0] value,
  output logic             adc_done,
  output logic      [13:0] adc_result
);
  int cnt;

  // Outside the done cycle the bus shows junk, so a late sample cannot pass
  assign adc_result = adc_done ? value : ~value;

  always @(posedge clk)
  begin
    adc_done <= 1'b0;
    if (rst)
    begin
      cnt <= 0;
    end
    else if (conv_start === 1'b1)
    begin
      cnt <= DELAY;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
        adc_done <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// [sensor_regs_nvm_shadow_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module sensor_regs_nvm_shadow_tb_top;
  // Arbitrary value, not tied to any real part
  localparam logic [15:0] DIE_ID_TB = 16'hC35A;

  logic        clk, rst, wr_en, rd_en, rd_valid, conv_start, adc_done;
  logic [3:0]  ptr;
  logic [15:0] wr_data, rd_data, rd_word;
  logic [13:0] adc_result, adc_val;
  logic        a1_o, a1_oe_n, a2_o, a2_oe_n;
  wire         alert_wire_one, alert_wire_two;
  int          err_count, n_compared;

  // Pull-ups on both open-drain pins
  assign alert_wire_one = a1_oe_n ? 1'b1 : a1_o;
  assign alert_wire_two = a2_oe_n ? 1'b1 : a2_o;

  sensor_regs_nvm_shadow #(
    .PROG_CYCLES   (20),
    .STRETCH_CYCLES(12),
    .MS_CYCLES     (10),
    .DIE_ID        (DIE_ID_TB)
  ) i_sensor_regs_nvm_shadow (
    .clk                  (clk),
    .rst                  (rst),
    .register_pointer_bits(ptr),
    .wr_en                (wr_en),
    .wr_data              (wr_data),
    .rd_en                (rd_en),
    .rd_data              (rd_data),
    .rd_valid             (rd_valid),
    .conv_start           (conv_start),
    .adc_done             (adc_done),
    .adc_result           (adc_result),
    .alert_output_one_o   (a1_o),
    .alert_output_one_oe_n(a1_oe_n),
    .alert_output_two_o   (a2_o),
    .alert_output_two_oe_n(a2_oe_n)
  );

  sensor_adc_model i_sensor_adc_model (
    .clk       (clk),
    .rst       (rst),
    .conv_start(conv_start),
    .value     (adc_val),
    .adc_done  (adc_done),
    .adc_result(adc_result)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Checking and access tasks
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t pin got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    @(negedge clk);
    ptr = p;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // Answer stands one cycle; fast reads answer on the taking edge itself
  task automatic rd_raw(input logic [3:0] p);
    int n;
    n = 0;
    @(negedge clk);
    ptr = p;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    while (n < 40 && rd_valid !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    rd_word = rd_data;
    if (n == 40)
      chk_bit(1'b0, 1'b1);
  endtask

  task automatic rd_check(input logic [3:0] p, input logic [15:0] exp);
    rd_raw(p);
    chk_word(rd_word, exp);
  endtask

  task automatic wait_conv;
    int n;
    n = 0;
    while (n < 100 && adc_done !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(adc_done, 1'b1);
    repeat (3) @(negedge clk);
  endtask

  // Start pulse stands one cycle, so one sample per negedge counts it once
  task automatic count_starts(input int cycles, input int exp);
    int n;
    n = 0;
    repeat (cycles)
    begin
      @(negedge clk);
      if (conv_start === 1'b1)
        n++;
    end
    chk_word(16'(n), 16'(exp));
  endtask

  task automatic do_reset(input int n);
    @(negedge clk);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD %0t run did not finish", $time);
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ptr = 4'h0;
    wr_data = 16'h0000;
    adc_val = 14'h0123;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd_check(4'h0, 16'h0000);
    wait_conv();
    rd_check(4'h0, 16'h048C);
    rd_check(4'hF, DIE_ID_TB);
    rd_check(4'hE, 16'h0000);
    rd_check(4'h1, 16'hA000);
    rd_check(4'h2, 16'h7FFC);
    rd_check(4'h3, 16'h8000);
    // Locked: general word refuses, limit takes it in logic only
    wr(4'h6, 16'hBEEF);
    rd_check(4'h6, 16'h0000);
    wr(4'h4, 16'h0400);
    rd_check(4'h0, 16'h048C);
    rd_check(4'h4, 16'h0400);
    // Unlocked programming with refused writes meanwhile
    wr(4'h0, 16'h0001);
    rd_check(4'h0, 16'h048D);
    wr(4'h7, 16'h1234);
    rd_check(4'h0, 16'h048F);
    wr(4'h0, 16'h0000);
    wr(4'h8, 16'h5555);
    rd_check(4'h0, 16'h048F);
    // Next write waits for busy to drop
    repeat (30) @(posedge clk);
    rd_check(4'h0, 16'h048D);
    rd_check(4'h7, 16'h1234);
    rd_check(4'h8, 16'h0000);
    wr(4'h0, 16'h0000);
    rd_check(4'h0, 16'h048C);
    // Reload after a hard and a soft reset
    do_reset(2);
    rd_check(4'h0, 16'h0000);
    rd_check(4'h7, 16'h1234);
    rd_check(4'h4, 16'h7FFC);
    wr(4'h2, 16'h1000);
    wr(4'h1, 16'h0002);
    rd_check(4'h2, 16'h7FFC);
    // Comparators and pins
    adc_val = 14'h0080;
    wr(4'h1, 16'h0808);
    wr(4'h2, 16'h0100);
    chk_bit(alert_wire_one, 1'b1);
    chk_bit(alert_wire_two, 1'b0);
    wr(4'h1, 16'h1808);
    wait_conv();
    chk_bit(alert_wire_one, 1'b0);
    rd_check(4'h1, 16'h0C08);
    rd_check(4'h1, 16'h0808);
    wr(4'h1, 16'h1908);
    wait_conv();
    rd_check(4'h1, 16'h0D08);
    rd_check(4'h1, 16'h0D08);
    // Conversion pacing
    count_starts(200, 0);
    wr(4'h1, 16'h0000);
    count_starts(320, 3);
    test_done();
  end
endmodule

`default_nettype wire
